// *** sim/stf_prot_model.sv ***
// Protection-side model: contact matrix, trip and phase currents.
// Assumes the bench steers it from aclk-synchronous controls.
`timescale 1ns/10ps
`default_nettype none
module stf_prot_model (
  input  wire logic  aclk,
  input  wire logic  trip_req,
  input  wire logic  oc_req,
  output logic [7:0]  normal_out,
  output logic        protection_trip_command,
  output logic [47:0] phase_current
);
  // Healthy current sits exactly at the abort threshold
  always_ff @(posedge aclk) begin
    normal_out              <= 8'h05;
    protection_trip_command <= trip_req;
    phase_current           <= {16'h0064, oc_req ? 16'h0065 : 16'h0064,
                                16'h0064};
  end
endmodule : stf_prot_model
`default_nettype wire

// *** sim/stf_tb_top.sv ***
// Self-checking bench of the service test and fault simulator.
// Assumes stf_defs.svh on the include path; timing counts shortened.
`timescale 1ns/10ps
`default_nettype none
`include "stf_defs.svh"
module stf_tb_top
  import stf_pkg::*;
;
  logic         aclk, aresetn, trip_req, oc_req, blk_a, blk_b, fpost, ext;
  logic [7:0]   disarm, relay_out, normal_out;
  logic         prot_trip, trip_cmd, sc;
  logic [47:0]  ph_cur;
  logic [63:0]  t_out, t_meas, t_disp;
  logic         prot_en, run_o, halt, log_wr;
  logic [31:0]  freq;
  logic [2:0]   code;
  logic [1:0]   last_resp;
  logic [31:0]  rdat;
  stf_axi_req_t req;
  stf_axi_rsp_t rsp;
  int           errors, n_checks, cyc, n_log;
  // Columns: select, value, config, disarm, wait, expected contacts
  localparam logic [31:0] T [6][6] = '{
    '{32'hFF, 32'hA5, 32'h4, 32'h0, 32'h3, 32'hA5},
    '{32'hFF, 32'hA5, 32'h7, 32'h0, 32'h3, 32'hFF},
    '{32'hFF, 32'hA5, 32'h7, 32'hF, 32'h3, 32'hF5},
    '{32'hFF, 32'hFF, 32'h20000, 32'h0, 32'h3, 32'hFF},
    '{32'hFF, 32'hFF, 32'h20000, 32'h0, 32'h28, 32'h05},
    '{32'h0, 32'h0, 32'h0, 32'h0, 32'h3, 32'h05}};

  stf_top #(.MS_CYC(4), .RST_CYC(10), .SC_CYC(20), .REC_CYC(20)) i_stf_top (
    .aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .normal_out(normal_out), .disarm(disarm), .relay_out(relay_out),
    .protection_trip_command(prot_trip), .trip_cmd_out(trip_cmd),
    .sys_ok(1'b1), .self_supervision_contact(sc), .sv_log_wr(log_wr),
    .temp_measured(t_meas), .temp_out(t_out),
    .temp_display(t_disp), .phase_current(ph_cur), .sim_block_input_a(blk_a),
    .sim_block_input_b(blk_b), .forced_post_fault_input(fpost),
    .external_sim_start(ext), .sim_state_code(code), .sim_running(run_o),
    .protection_enable(prot_en), .energy_count_halt(halt),
    .sim_freq_mhz(freq));
  stf_prot_model i_stf_prot_model (.aclk(aclk), .trip_req(trip_req),
    .oc_req(oc_req), .normal_out(normal_out),
    .protection_trip_command(prot_trip), .phase_current(ph_cur));

  always #12.5 aclk = ~aclk;

  task automatic end_sim;
    if (errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  always @(posedge aclk) begin
    cyc++;
    if (log_wr === 1'b1)
      n_log++;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [31:0] g, e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s exp %0h got %0h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge aclk);
    req.awaddr  <= {24'h0, a};
    req.wdata   <= d;
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge aclk);
      aw = rsp.awready;
      w = rsp.wready;
      b = rsp.bvalid;
      last_resp = rsp.bresp;
      @(posedge aclk);
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic ar, r;
    @(posedge aclk);
    req.araddr  <= {24'h0, a};
    req.arvalid <= 1'b1;
    r = 1'b0;
    while (!r) begin
      @(negedge aclk);
      ar = rsp.arready;
      r = rsp.rvalid;
      d = rsp.rdata;
      @(posedge aclk);
      if (ar) req.arvalid <= 1'b0;
    end
  endtask : rd

  task automatic wait_code(input logic [2:0] c, input int n);
    int k;
    k = 0;
    @(negedge aclk);
    while (code !== c && k < n) begin
      @(negedge aclk);
      k++;
    end
    chk("code", 32'(code), 32'(c));
  endtask : wait_code

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {trip_req, oc_req, blk_a, blk_b, fpost, ext} = 6'h0;
    disarm = 8'h00;
    t_meas = 64'h0055005500550055;
    req = '0;
    req.wstrb = 4'hF;
    req.bready = 1'b1;
    req.rready = 1'b1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    wait_code(3'h0, 0);
    rd(`STF_OFS_SIM_FREQ, rdat);
    chk("freq", rdat, 32'hC3A0);
    chk("freq_o", freq, 32'hC3A0);
    wr(8'h30, 32'h0);
    chk("bresp", 32'(last_resp), 32'h2);
    for (int i = 0; i < 6; i++) begin
      @(posedge aclk);
      disarm <= T[i][3][7:0];
      wr(`STF_OFS_OUT_CFG, T[i][2]);
      wr(`STF_OFS_OUT_SEL, T[i][0]);
      wr(`STF_OFS_OUT_VAL, T[i][1]);
      repeat (T[i][4]) @(negedge aclk);
      chk("relay", 32'(relay_out), T[i][5]);
    end
    wr(`STF_OFS_CTRL, 32'h4);
    repeat (2) @(negedge aclk);
    chk("trip", 32'(trip_cmd), 32'h1);
    wr(`STF_OFS_CTRL, 32'h8);
    chk("sc", 32'(sc), 32'h0);
    rd(`STF_OFS_LOG_CNT, rdat);
    chk("log", rdat, 32'h1);
    chk("log_wr", n_log, 32'h1);
    repeat (25) @(negedge aclk);
    chk("sc", 32'(sc), 32'h1);
    wr(`STF_OFS_TMP_VAL, 32'h0123);
    wr(`STF_OFS_TMP_CTRL, 32'h3);
    t_meas <= 64'h0066006600660066;
    repeat (2) @(negedge aclk);
    chk("temp", t_out[31:0], 32'h01230123);
    chk("disp", t_disp[31:0], 32'h00550055);
    wr(`STF_OFS_TMP_CTRL, 32'h0);
    wr(`STF_OFS_TMP_CTRL, 32'h20001);
    repeat (2) @(negedge aclk);
    chk("disp", t_disp[31:0], 32'h00660066);
    chk("temp", t_out[31:0], 32'h01230123);
    repeat (16) @(negedge aclk);
    chk("temp", t_out[31:0], 32'h00660066);
    trip_req <= 1'b1;
    wr(`STF_OFS_CTRL, 32'h0);
    wr(`STF_OFS_PH_PRE, 32'h5);
    wr(`STF_OFS_PH_FLT, 32'h5);
    wr(`STF_OFS_PH_POST, 32'h5);
    wr(`STF_OFS_CTRL, 32'h1);
    wait_code(3'h4, 5);
    chk("prot_en", 32'(prot_en), 32'h0);
    wait_code(3'h1, 20);
    chk("halt", 32'({run_o, halt}), 32'h3);
    wait_code(3'h2, 30);
    chk("trip", 32'(trip_cmd), 32'h0);
    wait_code(3'h3, 30);
    wait_code(3'h4, 30);
    wait_code(3'h0, 20);
    chk("halt", 32'({run_o, halt, prot_en}), 32'h1);
    wr(`STF_OFS_CTRL, 32'h11);
    wait_code(3'h2, 60);
    chk("trip", 32'(trip_cmd), 32'h1);
    wr(`STF_OFS_CTRL, 32'h12);
    wait_code(3'h0, 3);
    wr(`STF_OFS_CTRL, 32'h1);
    wait_code(3'h1, 20);
    @(posedge aclk);
    fpost <= 1'b1;
    wait_code(3'h3, 3);
    @(posedge aclk);
    fpost <= 1'b0;
    wr(`STF_OFS_CTRL, 32'h2);
    for (int i = 0; i < 2; i++) begin
      @(posedge aclk);
      {blk_b, blk_a} <= i ? 2'h2 : 2'h1;
      wr(`STF_OFS_CTRL, 32'h1);
      wait_code(3'h0, 0);
    end
    @(posedge aclk);
    {blk_b, blk_a} <= 2'h0;
    ext <= 1'b1;
    wait_code(3'h4, 3);
    oc_req <= 1'b1;
    wait_code(3'h0, 4);
    @(posedge aclk);
    {oc_req, ext} <= 2'h0;
    wr(`STF_OFS_CTRL, 32'h1);
    wait_code(3'h0, 0);
    repeat (25) @(posedge aclk);
    wr(`STF_OFS_CTRL, 32'h1);
    wait_code(3'h4, 3);
    end_sim();
  end
endmodule : stf_tb_top
`default_nettype wire

// *** src/stf_defs.svh ***
// Offsets, field positions, state codes and time figures of the
// service test and fault simulator block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef STF_DEFS_SVH
`define STF_DEFS_SVH

`define STF_CLK_HZ        40000000
`define STF_MS_PER_S      1000

// Register byte offsets
`define STF_OFS_CTRL      8'h00
`define STF_OFS_OUT_SEL   8'h04
`define STF_OFS_OUT_VAL   8'h08
`define STF_OFS_OUT_CFG   8'h0C
`define STF_OFS_TMP_CTRL  8'h10
`define STF_OFS_TMP_VAL   8'h14
`define STF_OFS_PH_PRE    8'h18
`define STF_OFS_PH_FLT    8'h1C
`define STF_OFS_PH_POST   8'h20
`define STF_OFS_STATUS    8'h24
`define STF_OFS_LOG_CNT   8'h28
`define STF_OFS_SIM_FREQ  8'h2C

// Control register bits
`define STF_CTRL_START    0
`define STF_CTRL_STOP     1
`define STF_CTRL_TRIP     2
`define STF_CTRL_SC_DROP  3
`define STF_CTRL_HOT      4

// Output force config bits
`define STF_OCFG_GRP_EN   0
`define STF_OCFG_GRP_VAL  1
`define STF_OCFG_PERM     2
`define STF_TMO_LSB       16

// Temperature force control bits
`define STF_TCTL_MODE     0
`define STF_TCTL_PERM     1

// Simulator state codes
`define STF_CODE_NORMAL   3'h0
`define STF_CODE_PRE      3'h1
`define STF_CODE_FAULT    3'h2
`define STF_CODE_POST     3'h3
`define STF_CODE_RESET    3'h4

// Time figures in their own units
`define STF_SC_DROP_S     5
`define STF_RST_MS        100
`define STF_REC_S         5

// Overcurrent abort at 1/10 of nominal
`define STF_ABORT_NUM     1
`define STF_ABORT_DEN     10

// Simulation frequency offset, parts per ten thousand
`define STF_FREQ_PPTT     16
`define STF_FREQ_DEN      10000

`define STF_RESP_OKAY     2'h0
`define STF_RESP_SLVERR   2'h2

`endif

// *** src/stf_pkg.sv ***
// Types of the service test and fault simulator block.
// Assumes stf_defs.svh is on the include path.
`include "stf_defs.svh"

package stf_pkg;

  typedef enum logic [2:0] {
    STF_IDLE,
    STF_RST1,
    STF_PRE,
    STF_FAULT,
    STF_POST,
    STF_RST2
  } stf_sim_st_t;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } stf_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } stf_axi_rsp_t;

endpackage : stf_pkg

// *** src/stf_top.sv ***
// Service test forcing, supervision contact drop, temperature forcing
// and fault simulator sequencer, with an AXI4-Lite register slave.
// Assumes all protection-side inputs come from logic on aclk.
`timescale 1ns/10ps
`default_nettype none
`include "stf_defs.svh"

module stf_top
  import stf_pkg::*;
#(
  parameter int N_OUT       = 8,
  parameter int N_TMP       = 4,
  parameter int TW          = 16,
  parameter int IW          = 16,
  parameter int I_NOM       = 1000,
  parameter int RATED_MHZ   = 50000,
  parameter int MS_CYC      = `STF_CLK_HZ / `STF_MS_PER_S,
  parameter int RST_CYC     = `STF_RST_MS * (`STF_CLK_HZ / `STF_MS_PER_S),
  parameter int SC_CYC      = `STF_SC_DROP_S * `STF_CLK_HZ,
  parameter int REC_CYC     = `STF_REC_S * `STF_CLK_HZ
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire stf_axi_req_t       axi_req,
  output stf_axi_rsp_t            axi_rsp,
  input  wire logic [N_OUT-1:0]   normal_out,
  input  wire logic [N_OUT-1:0]   disarm,
  output logic [N_OUT-1:0]        relay_out,
  input  wire logic               protection_trip_command,
  output logic                    trip_cmd_out,
  input  wire logic               sys_ok,
  output logic                    self_supervision_contact,
  output logic                    sv_log_wr,
  input  wire logic [N_TMP*TW-1:0] temp_measured,
  output logic [N_TMP*TW-1:0]     temp_out,
  output logic [N_TMP*TW-1:0]     temp_display,
  input  wire logic [3*IW-1:0]    phase_current,
  input  wire logic               sim_block_input_a,
  input  wire logic               sim_block_input_b,
  input  wire logic               forced_post_fault_input,
  input  wire logic               external_sim_start,
  output logic [2:0]              sim_state_code,
  output logic                    sim_running,
  output logic                    protection_enable,
  output logic                    energy_count_halt,
  output logic [31:0]             sim_freq_mhz
);

  localparam logic [IW-1:0] THR =
    IW'(I_NOM * `STF_ABORT_NUM / `STF_ABORT_DEN);
  localparam logic [31:0] FREQ =
    32'(RATED_MHZ + RATED_MHZ * `STF_FREQ_PPTT / `STF_FREQ_DEN);

  initial begin
    if (N_OUT < 1 || N_OUT > 16 || N_TMP < 1 || TW < 1 || TW > 16 ||
        IW < 1 || MS_CYC < 1 || RST_CYC < 1 || SC_CYC < 1 ||
        REC_CYC < 1)
      $error("stf_top: unsupported parameter values");
  end

  typedef struct packed {
    logic              aw_got;
    logic [7:0]        aw_addr;
    logic              w_got;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              hot;
    logic              trip_force;
    logic [N_OUT-1:0]  out_sel;
    logic [N_OUT-1:0]  out_val;
    logic              grp_en;
    logic              grp_val;
    logic              out_perm;
    logic [15:0]       out_tmo;
    logic [15:0]       out_cnt;
    logic              tmp_mode;
    logic              tmp_perm;
    logic [15:0]       tmp_tmo;
    logic [15:0]       tmp_cnt;
    logic              tmp_live;
    logic [TW-1:0]     tmp_val;
    logic [N_TMP*TW-1:0] tmp_disp;
    logic [N_TMP*TW-1:0] tmp_out;
    logic [15:0]       ph_pre;
    logic [15:0]       ph_flt;
    logic [15:0]       ph_post;
    stf_sim_st_t       st;
    logic [31:0]       ph_cnt;
    logic [31:0]       ms_cnt;
    logic              lock;
    logic [31:0]       rec_cnt;
    logic              xs_prev;
    logic              fp_prev;
    logic              sc_drop;
    logic [31:0]       sc_cnt;
    logic              log_pulse;
    logic [15:0]       log_cnt;
    logic [N_OUT-1:0]  relay;
    logic              trip;
  } stf_state_t;

  stf_state_t s_r;
  stf_state_t s_nxt;

  logic       aw_hs;
  logic       w_hs;
  logic       do_wr;
  logic       wr_ctrl;
  logic       ms_tick;
  logic       over;
  logic       blk;
  logic       run;
  logic       start_req;
  logic       fp_rise;

  assign aw_hs = axi_req.awvalid && !s_r.aw_got && !s_r.bvalid;
  assign w_hs  = axi_req.wvalid && !s_r.w_got && !s_r.bvalid;
  assign do_wr = s_r.aw_got && s_r.w_got && !s_r.bvalid;
  assign wr_ctrl = do_wr && s_r.aw_addr == `STF_OFS_CTRL && s_r.wstrb[0];
  assign ms_tick = s_r.ms_cnt == 32'(MS_CYC - 1);
  assign blk = sim_block_input_a || sim_block_input_b;
  assign run = s_r.st != STF_IDLE;
  assign fp_rise = forced_post_fault_input && !s_r.fp_prev;
  assign start_req = (wr_ctrl && s_r.wdata[`STF_CTRL_START]) ||
                     (external_sim_start && !s_r.xs_prev);

  always_comb begin
    over = 1'b0;
    for (int p = 0; p < 3; p++) begin
      if (phase_current[p*IW +: IW] > THR)
        over = 1'b1;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b])
        r[b*8 +: 8] = dat[b*8 +: 8];
    end
    return r;
  endfunction : merge

  function automatic logic [2:0] code_of(input stf_sim_st_t st);
    unique case (st)
      STF_IDLE:           code_of = `STF_CODE_NORMAL;
      STF_PRE:            code_of = `STF_CODE_PRE;
      STF_FAULT:          code_of = `STF_CODE_FAULT;
      STF_POST:           code_of = `STF_CODE_POST;
      STF_RST1, STF_RST2: code_of = `STF_CODE_RESET;
      default:            code_of = `STF_CODE_NORMAL;
    endcase
  endfunction : code_of

  always_comb begin
    logic [31:0] m;
    logic [31:0] oc;
    logic [31:0] tc;
    logic        ofw;
    logic        tfw;
    logic        tick_ph;
    logic [15:0] dur;
    m = 32'h0;
    oc = 32'h0;
    tc = 32'h0;
    ofw = 1'b0;
    tfw = 1'b0;
    tick_ph = 1'b0;
    dur = 16'h0;
    s_nxt = s_r;
    s_nxt.log_pulse = 1'b0;
    s_nxt.xs_prev = external_sim_start;
    s_nxt.fp_prev = forced_post_fault_input;
    s_nxt.ms_cnt = ms_tick ? 32'h0 : s_r.ms_cnt + 32'h1;

    // Bus: address and data in either order, response after both
    if (aw_hs) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.aw_addr = axi_req.awaddr[7:0];
    end
    if (w_hs) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = axi_req.wdata;
      s_nxt.wstrb = axi_req.wstrb;
    end
    if (s_r.bvalid && axi_req.bready)
      s_nxt.bvalid = 1'b0;
    if (do_wr) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = `STF_RESP_OKAY;
      oc = {s_r.out_tmo, 13'h0, s_r.out_perm, s_r.grp_val, s_r.grp_en};
      tc = {s_r.tmp_tmo, 14'h0, s_r.tmp_perm, s_r.tmp_mode};
      unique case (s_r.aw_addr)
        `STF_OFS_CTRL: begin
          m = merge({27'h0, s_r.hot, 1'b0, s_r.trip_force, 2'h0},
                    s_r.wdata, s_r.wstrb);
          s_nxt.hot = m[`STF_CTRL_HOT];
          s_nxt.trip_force = m[`STF_CTRL_TRIP];
        end
        `STF_OFS_OUT_SEL: begin
          m = merge(32'(s_r.out_sel), s_r.wdata, s_r.wstrb);
          s_nxt.out_sel = m[N_OUT-1:0] & ~disarm;
          ofw = 1'b1;
        end
        `STF_OFS_OUT_VAL: begin
          m = merge(32'(s_r.out_val), s_r.wdata, s_r.wstrb);
          s_nxt.out_val = m[N_OUT-1:0];
        end
        `STF_OFS_OUT_CFG: begin
          m = merge(oc, s_r.wdata, s_r.wstrb);
          s_nxt.grp_en = m[`STF_OCFG_GRP_EN];
          s_nxt.grp_val = m[`STF_OCFG_GRP_VAL];
          s_nxt.out_perm = m[`STF_OCFG_PERM];
          s_nxt.out_tmo = m[31:`STF_TMO_LSB];
          ofw = 1'b1;
        end
        `STF_OFS_TMP_CTRL: begin
          m = merge(tc, s_r.wdata, s_r.wstrb);
          s_nxt.tmp_mode = m[`STF_TCTL_MODE];
          s_nxt.tmp_perm = m[`STF_TCTL_PERM];
          s_nxt.tmp_tmo = m[31:`STF_TMO_LSB];
          tfw = m[`STF_TCTL_MODE] && !s_r.tmp_mode;
        end
        `STF_OFS_TMP_VAL: begin
          m = merge(32'(s_r.tmp_val), s_r.wdata, s_r.wstrb);
          s_nxt.tmp_val = m[TW-1:0];
        end
        `STF_OFS_PH_PRE: begin
          m = merge({16'h0, s_r.ph_pre}, s_r.wdata, s_r.wstrb);
          s_nxt.ph_pre = m[15:0];
        end
        `STF_OFS_PH_FLT: begin
          m = merge({16'h0, s_r.ph_flt}, s_r.wdata, s_r.wstrb);
          s_nxt.ph_flt = m[15:0];
        end
        `STF_OFS_PH_POST: begin
          m = merge({16'h0, s_r.ph_post}, s_r.wdata, s_r.wstrb);
          s_nxt.ph_post = m[15:0];
        end
        `STF_OFS_STATUS, `STF_OFS_LOG_CNT, `STF_OFS_SIM_FREQ: ;
        default: s_nxt.bresp = `STF_RESP_SLVERR;
      endcase
    end
    if (axi_req.arvalid && !s_r.rvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = `STF_RESP_OKAY;
      unique case (axi_req.araddr[7:0])
        `STF_OFS_CTRL:
          s_nxt.rdata = {27'h0, s_r.hot, 1'b0, s_r.trip_force, 2'h0};
        `STF_OFS_OUT_SEL:  s_nxt.rdata = 32'(s_r.out_sel);
        `STF_OFS_OUT_VAL:  s_nxt.rdata = 32'(s_r.out_val);
        `STF_OFS_OUT_CFG:
          s_nxt.rdata = {s_r.out_tmo, 13'h0, s_r.out_perm,
                         s_r.grp_val, s_r.grp_en};
        `STF_OFS_TMP_CTRL:
          s_nxt.rdata = {s_r.tmp_tmo, 14'h0, s_r.tmp_perm, s_r.tmp_mode};
        `STF_OFS_TMP_VAL:  s_nxt.rdata = 32'(s_r.tmp_val);
        `STF_OFS_PH_PRE:   s_nxt.rdata = {16'h0, s_r.ph_pre};
        `STF_OFS_PH_FLT:   s_nxt.rdata = {16'h0, s_r.ph_flt};
        `STF_OFS_PH_POST:  s_nxt.rdata = {16'h0, s_r.ph_post};
        `STF_OFS_STATUS:
          s_nxt.rdata = {23'h0, s_r.tmp_live, s_r.grp_en, s_r.sc_drop,
                         s_r.lock, run, code_of(s_r.st)};
        `STF_OFS_LOG_CNT:  s_nxt.rdata = {16'h0, s_r.log_cnt};
        `STF_OFS_SIM_FREQ: s_nxt.rdata = FREQ;
        default: begin
          s_nxt.rdata = 32'h0;
          s_nxt.rresp = `STF_RESP_SLVERR;
        end
      endcase
    end else if (s_r.rvalid && axi_req.rready) begin
      s_nxt.rvalid = 1'b0;
    end

    // Output force timer
    if (ofw) begin
      s_nxt.out_cnt = s_nxt.out_tmo;
    end else if (ms_tick && !s_r.out_perm &&
                 (s_r.grp_en || s_r.out_sel != '0)) begin
      if (s_r.out_cnt == 16'h0) begin
        s_nxt.out_sel = '0;
        s_nxt.grp_en = 1'b0;
      end else begin
        s_nxt.out_cnt = s_r.out_cnt - 16'h1;
      end
    end
    for (int i = 0; i < N_OUT; i++) begin
      if (disarm[i])
        s_nxt.relay[i] = normal_out[i];
      else if (s_r.grp_en)
        s_nxt.relay[i] = s_r.grp_val;
      else if (s_r.out_sel[i])
        s_nxt.relay[i] = s_r.out_val[i];
      else
        s_nxt.relay[i] = normal_out[i];
    end

    // Trip: manual force, or protection trip unless cold simulation
    s_nxt.trip = s_r.trip_force ||
                 (protection_trip_command && (!run || s_r.hot));

    // Supervision contact drop
    if (wr_ctrl && s_r.wdata[`STF_CTRL_SC_DROP]) begin
      s_nxt.sc_drop = 1'b1;
      s_nxt.sc_cnt = 32'h0;
      s_nxt.log_pulse = 1'b1;
      s_nxt.log_cnt = s_r.log_cnt + 16'h1;
    end else if (s_r.sc_drop) begin
      if (s_r.sc_cnt == 32'(SC_CYC - 1))
        s_nxt.sc_drop = 1'b0;
      else
        s_nxt.sc_cnt = s_r.sc_cnt + 32'h1;
    end

    // Temperature forcing and display freeze
    if (!s_r.tmp_mode) begin
      s_nxt.tmp_live = 1'b0;
      s_nxt.tmp_disp = temp_measured;
    end else if (tfw) begin
    end else if (ms_tick && s_r.tmp_live && !s_r.tmp_perm) begin
      if (s_r.tmp_cnt == 16'h0)
        s_nxt.tmp_live = 1'b0;
      else
        s_nxt.tmp_cnt = s_r.tmp_cnt - 16'h1;
    end
    if (tfw) begin
      s_nxt.tmp_live = 1'b1;
      s_nxt.tmp_cnt = s_nxt.tmp_tmo;
      s_nxt.tmp_disp = temp_measured;
    end
    for (int k = 0; k < N_TMP; k++) begin
      s_nxt.tmp_out[k*TW +: TW] = s_r.tmp_live ? s_r.tmp_val :
                                  temp_measured[k*TW +: TW];
    end

    // Overcurrent lockout recovery
    if (over) begin
      s_nxt.rec_cnt = 32'h0;
    end else if (s_r.lock) begin
      if (s_r.rec_cnt == 32'(REC_CYC - 1))
        s_nxt.lock = 1'b0;
      else
        s_nxt.rec_cnt = s_r.rec_cnt + 32'h1;
    end

    // Sequencer
    unique case (s_r.st)
      STF_PRE:   dur = s_r.ph_pre;
      STF_FAULT: dur = s_r.ph_flt;
      STF_POST:  dur = s_r.ph_post;
      default:   dur = 16'h0;
    endcase
    tick_ph = ms_tick && 32'(dur) <= s_r.ph_cnt + 32'h1;
    if (run && ms_tick)
      s_nxt.ph_cnt = s_r.ph_cnt + 32'h1;
    if (run && over) begin
      s_nxt.st = STF_IDLE;
      s_nxt.lock = 1'b1;
      s_nxt.rec_cnt = 32'h0;
    end else if (run && (blk || (wr_ctrl && s_r.wdata[`STF_CTRL_STOP]))) begin
      s_nxt.st = STF_IDLE;
    end else begin
      unique case (s_r.st)
        STF_IDLE: begin
          if (start_req && !blk && !s_r.lock && !over) begin
            s_nxt.st = STF_RST1;
            s_nxt.ph_cnt = 32'h0;
          end
        end
        STF_RST1, STF_RST2: begin
          s_nxt.ph_cnt = s_r.ph_cnt + 32'h1;
          if (s_r.ph_cnt == 32'(RST_CYC - 1)) begin
            s_nxt.st = s_r.st == STF_RST1 ? STF_PRE : STF_IDLE;
            s_nxt.ph_cnt = 32'h0;
          end
        end
        STF_PRE, STF_FAULT: begin
          if (fp_rise || tick_ph) begin
            s_nxt.st = (fp_rise || s_r.st == STF_FAULT) ?
                       STF_POST : STF_FAULT;
            s_nxt.ph_cnt = 32'h0;
          end
        end
        STF_POST: begin
          if (tick_ph) begin
            s_nxt.st = STF_RST2;
            s_nxt.ph_cnt = 32'h0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.st <= STF_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign axi_rsp.awready = !s_r.aw_got && !s_r.bvalid;
  assign axi_rsp.wready  = !s_r.w_got && !s_r.bvalid;
  assign axi_rsp.bvalid  = s_r.bvalid;
  assign axi_rsp.bresp   = s_r.bresp;
  assign axi_rsp.arready = !s_r.rvalid;
  assign axi_rsp.rvalid  = s_r.rvalid;
  assign axi_rsp.rdata   = s_r.rdata;
  assign axi_rsp.rresp   = s_r.rresp;
  assign relay_out = s_r.relay;
  assign trip_cmd_out = s_r.trip;
  assign self_supervision_contact = sys_ok && !s_r.sc_drop;
  assign sv_log_wr = s_r.log_pulse;
  assign temp_out = s_r.tmp_out;
  assign temp_display = s_r.tmp_disp;
  assign sim_state_code = code_of(s_r.st);
  assign sim_running = run;
  assign protection_enable = !(s_r.st == STF_RST1 || s_r.st == STF_RST2);
  assign energy_count_halt = run;
  assign sim_freq_mhz = FREQ;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_abort_over: assert property (run && over |=>
    s_r.st == STF_IDLE && s_r.lock) else $error("no overcurrent abort");
  a_lock_start: assert property (s_r.lock && !(over == 1'b0 &&
    s_r.rec_cnt == 32'(REC_CYC - 1)) |=> s_r.st == STF_IDLE)
    else $error("start during lockout");
  a_block_run: assert property (blk |=>
    s_r.st == STF_IDLE) else $error("simulator ran while blocked");
  a_fpost_jump: assert property ((s_r.st == STF_PRE ||
    s_r.st == STF_FAULT) && fp_rise && !over && !blk && !wr_ctrl |=>
    s_r.st == STF_POST) else $error("forced post jump missed");
  a_cold_block: assert property (run && !s_r.hot &&
    !s_r.trip_force |=> !trip_cmd_out) else $error("cold trip passed");
  a_stop_code: assert property (run && wr_ctrl &&
    s_r.wdata[`STF_CTRL_STOP] |=> sim_state_code == `STF_CODE_NORMAL)
    else $error("stop did not end simulation");
  a_sc_restore: assert property ($fell(s_r.sc_drop) |->
    $past(s_r.sc_cnt) == 32'(SC_CYC - 1)) else $error("drop length");
  a_grp_prio: assert property (s_r.grp_en && !disarm[0] |=>
    relay_out[0] == $past(s_r.grp_val)) else $error("group priority");
  a_disarm_pass: assert property (disarm[0] |=>
    relay_out[0] == $past(normal_out[0])) else $error("disarmed forced");
  a_rst_prot: assert property (s_r.st == STF_RST1 |->
    !protection_enable && sim_state_code == `STF_CODE_RESET)
    else $error("protection on in reset phase");
  a_log_entry: assert property (wr_ctrl &&
    s_r.wdata[`STF_CTRL_SC_DROP] |=> sv_log_wr && !self_supervision_contact)
    else $error("drop not logged");

  c_post: cover property (s_r.st == STF_POST ##1 s_r.st == STF_RST2);
  c_abort: cover property (run && over);
  c_fpost: cover property (s_r.st == STF_FAULT && fp_rise);
  c_sc_drop: cover property ($fell(s_r.sc_drop));

endmodule : stf_top
`default_nettype wire
